/* verilog/dsmd_defines.svh */
// Constants for the scaling and multiply datapath slice
`ifndef DSMD_DEFINES_SVH
`define DSMD_DEFINES_SVH

`define DSMD_DATA_W 16
`define DSMD_WIDE_W 32
`define DSMD_PROD_EXT_W 34
`define DSMD_ISHIFT_W 5
`define DSMD_ISHIFT_MAX 5'h10
`define DSMD_OSHIFT_W 3
`define DSMD_PSHIFT_L1 1
`define DSMD_PSHIFT_L4 4
`define DSMD_PSHIFT_R6 6
`define DSMD_HALF_HI_MSB 31
`define DSMD_HALF_HI_LSB 16
`define DSMD_HALF_LO_MSB 15
`define DSMD_HALF_LO_LSB 0
`define DSMD_ZERO_WIDE 32'h0000_0000
`define DSMD_ZERO_DATA 16'h0000

`endif

/* verilog/dsmd_pkg.sv */
// Types shared by the scaling and multiply datapath slice
package dsmd_pkg;

  // Product shifter settings
  typedef enum logic [1:0] {
    PSH_NONE,
    PSH_LEFT1,
    PSH_LEFT4,
    PSH_RIGHT6
  } dsmd_psh_t;

  // Main arithmetic unit operations
  typedef enum logic [2:0] {
    ALU_LOAD,
    ALU_ADD,
    ALU_SUB,
    ALU_AND,
    ALU_OR,
    ALU_XOR
  } dsmd_alu_op_t;

  // Operand source for the main arithmetic unit
  typedef enum logic {
    SRC_INPUT_SCALER,
    SRC_PRODUCT_SHIFTER
  } dsmd_src_t;

  // Source of the data write bus
  typedef enum logic {
    DWB_OUTPUT_SCALER,
    DWB_PRODUCT_SHIFTER
  } dsmd_dwb_src_t;

  // Half of a 32-bit word placed on the data write bus
  typedef enum logic {
    HALF_LOW,
    HALF_HIGH
  } dsmd_half_t;

  // Complete state of the datapath
  typedef struct packed {
    logic [31:0] accumulator_reg;
    logic [31:0] product_holding_reg;
    logic carry;
    logic [15:0] data_write_bus;
    logic write_valid;
  } dsmd_state_t;

endpackage

/* verilog/dsmd_multiplier_unit.sv */
// Single-cycle 16x16 multiplier, signed or unsigned
`timescale 1ns/100ps
`include "dsmd_defines.svh"

module dsmd_multiplier_unit (
  input wire logic [`DSMD_DATA_W-1:0] mul_a,
  input wire logic [`DSMD_DATA_W-1:0] mul_b,
  input wire logic mul_signed,
  output logic [`DSMD_WIDE_W-1:0] mul_product
);

  logic signed [`DSMD_DATA_W:0] ext_a;
  logic signed [`DSMD_DATA_W:0] ext_b;
  logic signed [`DSMD_PROD_EXT_W-1:0] full_product;

  // Extra top bit is the sign in signed mode, zero in unsigned mode
  always_comb begin
    ext_a = {mul_signed & mul_a[`DSMD_DATA_W-1], mul_a};
    ext_b = {mul_signed & mul_b[`DSMD_DATA_W-1], mul_b};
    full_product = ext_a * ext_b;
    mul_product = full_product[`DSMD_WIDE_W-1:0];
  end

endmodule // dsmd_multiplier_unit

/* verilog/dsmd_datapath.sv */
// Scaling shifters, multiplier, product register and main arithmetic unit
//
// Notes on behaviour
// - The input scaler widens a 16-bit operand to 32 bits shifted left by 0 to 16 places.
// - Input scaling is combinational within the operand cycle and adds no clock.
// - The multiplier forms the full 32-bit product of two 16-bit operands in one cycle.
// - Each multiply selects signed two's-complement or unsigned operation.
// - A 32-bit product register captures each product and holds it until the next one.
// - The product shifter passes, shifts left one, shifts left four or shifts right six.
// - The product shifter is combinational and adds no clock to any operation.
// - The shifted product can feed both the main arithmetic unit and the data write bus.
// - The output scaler shifts the 32-bit accumulator left by 0 to 7 places.
// - The output scaler puts the high or low 16 bits of the shifted value on the write bus.
// - The main arithmetic unit combines the accumulator with a scaled operand in one cycle.
`timescale 1ns/100ps
`include "dsmd_defines.svh"

module dsmd_datapath (
  input wire logic sys_clk,
  input wire logic reset_n,
  // Input scaler operand
  input wire logic [`DSMD_DATA_W-1:0] data_read_bus,
  input wire logic [`DSMD_ISHIFT_W-1:0] input_shift,
  // Multiplier request
  input wire logic mult_go,
  input wire logic mult_signed,
  input wire logic [`DSMD_DATA_W-1:0] mult_a,
  input wire logic [`DSMD_DATA_W-1:0] mult_b,
  // Product shifter setting
  input wire dsmd_pkg::dsmd_psh_t product_shift,
  // Main arithmetic unit request
  input wire logic alu_go,
  input wire dsmd_pkg::dsmd_alu_op_t alu_op,
  input wire dsmd_pkg::dsmd_src_t alu_src,
  // Data write bus request
  input wire logic write_go,
  input wire dsmd_pkg::dsmd_dwb_src_t write_src,
  input wire dsmd_pkg::dsmd_half_t write_half,
  input wire logic [`DSMD_OSHIFT_W-1:0] output_shift,
  // Results
  output logic [`DSMD_WIDE_W-1:0] accumulator_reg,
  output logic [`DSMD_WIDE_W-1:0] product_holding_reg,
  output logic alu_carry,
  output logic [`DSMD_DATA_W-1:0] data_write_bus,
  output logic data_write_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Shift functions

  // Zero-filling left shift of a 32-bit word
  function automatic logic [`DSMD_WIDE_W-1:0] shl32(
    input logic [`DSMD_WIDE_W-1:0] value,
    input logic [`DSMD_ISHIFT_W-1:0] amount
  );
    shl32 = value << amount;
  endfunction

  // Select one 16-bit half of a 32-bit word
  function automatic logic [`DSMD_DATA_W-1:0] pick_half(
    input logic [`DSMD_WIDE_W-1:0] value,
    input dsmd_pkg::dsmd_half_t half
  );
    if (half == dsmd_pkg::HALF_HIGH) begin
      pick_half = value[`DSMD_HALF_HI_MSB:`DSMD_HALF_HI_LSB];
    end else begin
      pick_half = value[`DSMD_HALF_LO_MSB:`DSMD_HALF_LO_LSB];
    end
  endfunction

  // 33-bit sum of two words and a carry in; the top bit is the carry out
  function automatic logic [`DSMD_WIDE_W:0] add_carry(
    input logic [`DSMD_WIDE_W-1:0] lhs,
    input logic [`DSMD_WIDE_W-1:0] rhs,
    input logic carry_in
  );
    add_carry = {1'b0, lhs} + {1'b0, rhs} + {`DSMD_ZERO_WIDE, carry_in};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  dsmd_pkg::dsmd_state_t state_q;
  dsmd_pkg::dsmd_state_t state_d;

  logic [`DSMD_WIDE_W-1:0] mult_result;
  logic [`DSMD_ISHIFT_W-1:0] in_amount;
  logic [`DSMD_WIDE_W-1:0] in_scaled;
  logic [`DSMD_WIDE_W-1:0] prod_scaled;
  logic [`DSMD_WIDE_W-1:0] out_scaled;
  logic [`DSMD_WIDE_W-1:0] alu_operand;
  logic [`DSMD_WIDE_W:0] alu_sum;

  ////////////////////////////////////////////////////////////////////////////////
  // Multiplier

  dsmd_multiplier_unit u_multiplier_unit (
    .mul_a(mult_a),
    .mul_b(mult_b),
    .mul_signed(mult_signed),
    .mul_product(mult_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Scalers, all combinational

  always_comb begin
    // Amounts above sixteen are held at sixteen
    if (input_shift > `DSMD_ISHIFT_MAX) begin
      in_amount = `DSMD_ISHIFT_MAX;
    end else begin
      in_amount = input_shift;
    end
    in_scaled = shl32({`DSMD_ZERO_DATA, data_read_bus}, in_amount);

    unique case (product_shift)
      dsmd_pkg::PSH_NONE: begin
        prod_scaled = state_q.product_holding_reg;
      end
      dsmd_pkg::PSH_LEFT1: begin
        prod_scaled = state_q.product_holding_reg << `DSMD_PSHIFT_L1;
      end
      dsmd_pkg::PSH_LEFT4: begin
        prod_scaled = state_q.product_holding_reg << `DSMD_PSHIFT_L4;
      end
      dsmd_pkg::PSH_RIGHT6: begin
        // Sign fill keeps signed product sums correct
        prod_scaled = $signed(state_q.product_holding_reg) >>> `DSMD_PSHIFT_R6;
      end
    endcase

    // Output scaler works on the registered accumulator
    out_scaled = shl32(state_q.accumulator_reg, {2'b00, output_shift});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;
    alu_sum = {1'b0, `DSMD_ZERO_WIDE};

    // Operand from the input scaler or the product shifter
    if (alu_src == dsmd_pkg::SRC_PRODUCT_SHIFTER) begin
      alu_operand = prod_scaled;
    end else begin
      alu_operand = in_scaled;
    end

    // Raw product is stored; scaling is applied on the way out
    if (mult_go) begin
      state_d.product_holding_reg = mult_result;
    end

    if (alu_go) begin
      unique case (alu_op)
        dsmd_pkg::ALU_LOAD: begin
          state_d.accumulator_reg = alu_operand;
        end
        dsmd_pkg::ALU_ADD: begin
          alu_sum = add_carry(state_q.accumulator_reg, alu_operand, 1'b0);
          state_d.accumulator_reg = alu_sum[`DSMD_WIDE_W-1:0];
          state_d.carry = alu_sum[`DSMD_WIDE_W];
        end
        dsmd_pkg::ALU_SUB: begin
          // Carry is set when no borrow occurs
          alu_sum = add_carry(state_q.accumulator_reg, ~alu_operand, 1'b1);
          state_d.accumulator_reg = alu_sum[`DSMD_WIDE_W-1:0];
          state_d.carry = alu_sum[`DSMD_WIDE_W];
        end
        dsmd_pkg::ALU_AND: begin
          state_d.accumulator_reg = state_q.accumulator_reg & alu_operand;
        end
        dsmd_pkg::ALU_OR: begin
          state_d.accumulator_reg = state_q.accumulator_reg | alu_operand;
        end
        dsmd_pkg::ALU_XOR: begin
          state_d.accumulator_reg = state_q.accumulator_reg ^ alu_operand;
        end
        default: begin
          state_d.accumulator_reg = state_q.accumulator_reg;
        end
      endcase
    end

    // Write bus takes the accumulator before this cycle's update
    state_d.write_valid = write_go;
    if (write_go) begin
      if (write_src == dsmd_pkg::DWB_PRODUCT_SHIFTER) begin
        state_d.data_write_bus = pick_half(prod_scaled, write_half);
      end else begin
        state_d.data_write_bus = pick_half(out_scaled, write_half);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset; every field starts at zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q.accumulator_reg <= `DSMD_ZERO_WIDE;
      state_q.product_holding_reg <= `DSMD_ZERO_WIDE;
      state_q.carry <= 1'b0;
      state_q.data_write_bus <= `DSMD_ZERO_DATA;
      state_q.write_valid <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Every output is a flip-flop of the state record
  assign accumulator_reg = state_q.accumulator_reg;
  assign product_holding_reg = state_q.product_holding_reg;
  assign alu_carry = state_q.carry;
  assign data_write_bus = state_q.data_write_bus;
  assign data_write_valid = state_q.write_valid;

endmodule // dsmd_datapath

/* verif/dsmd_datapath_sva.sv */
// Port assertions for the scaling and multiply datapath
`timescale 1ns/100ps
module dsmd_datapath_sva (
  input logic sys_clk,
  input logic reset_n,
  input logic [15:0] data_read_bus,
  input logic [4:0] input_shift,
  input logic mult_go,
  input logic mult_signed,
  input logic [15:0] mult_a,
  input logic [15:0] mult_b,
  input dsmd_pkg::dsmd_psh_t product_shift,
  input logic alu_go,
  input dsmd_pkg::dsmd_alu_op_t alu_op,
  input dsmd_pkg::dsmd_src_t alu_src,
  input logic write_go,
  input dsmd_pkg::dsmd_dwb_src_t write_src,
  input dsmd_pkg::dsmd_half_t write_half,
  input logic [2:0] output_shift,
  input logic [31:0] accumulator_reg,
  input logic [31:0] product_holding_reg,
  input logic [15:0] data_write_bus,
  input logic data_write_valid
);
  logic [31:0] p, prod_w, psh_w, opd_w, wsel_w;
  logic [15:0] wd_w;
  assign p = product_holding_reg;
  assign prod_w = {{16{mult_signed & mult_a[15]}}, mult_a} *
    {{16{mult_signed & mult_b[15]}}, mult_b};
  assign psh_w = product_shift == dsmd_pkg::PSH_LEFT1 ? p << 1 :
    product_shift == dsmd_pkg::PSH_LEFT4 ? p << 4 :
    product_shift == dsmd_pkg::PSH_RIGHT6 ? {{6{p[31]}}, p[31:6]} : p;
  assign opd_w = alu_src == dsmd_pkg::SRC_PRODUCT_SHIFTER ? psh_w :
    {16'h0, data_read_bus} << (input_shift > 5'h10 ? 5'h10 : input_shift);
  assign wsel_w = write_src == dsmd_pkg::DWB_PRODUCT_SHIFTER ? psh_w :
    accumulator_reg << output_shift;
  assign wd_w = write_half == dsmd_pkg::HALF_HIGH ? wsel_w[31:16] : wsel_w[15:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_load;
    alu_go && alu_op == dsmd_pkg::ALU_LOAD;
  endsequence
  sequence s_wr_done;
    data_write_valid && data_write_bus == $past(wd_w);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_prod_load: assert property (mult_go |=> p == $past(prod_w))
    else $error("product wrong");
  chk_prod_hold: assert property (!mult_go |=> $stable(p))
    else $error("product changed");
  chk_write_data: assert property (write_go |=> s_wr_done)
    else $error("write data wrong");
  chk_valid_once: assert property (!write_go |=> !data_write_valid)
    else $error("valid stuck");
  chk_wbus_hold: assert property (!write_go |=> $stable(data_write_bus))
    else $error("write bus changed");
  chk_alu_load: assert property (s_load |=> accumulator_reg == $past(opd_w))
    else $error("load wrong");
  chk_alu_add: assert property (alu_go && alu_op == dsmd_pkg::ALU_ADD |=>
    accumulator_reg == $past(accumulator_reg) + $past(opd_w)) else $error("add wrong");
  chk_acc_hold: assert property (!alu_go |=> $stable(accumulator_reg))
    else $error("acc changed");
endmodule // dsmd_datapath_sva

/* verif/dsmd_ctrl_model.sv */
// Controller model issuing datapath requests at the falling edge
`timescale 1ns/100ps
module dsmd_ctrl_model (
  input logic sys_clk,
  output logic [15:0] data_read_bus,
  output logic [4:0] input_shift,
  output logic mult_go,
  output logic mult_signed,
  output logic [15:0] mult_a,
  output logic [15:0] mult_b,
  output dsmd_pkg::dsmd_psh_t product_shift,
  output logic alu_go,
  output dsmd_pkg::dsmd_alu_op_t alu_op,
  output dsmd_pkg::dsmd_src_t alu_src,
  output logic write_go,
  output dsmd_pkg::dsmd_dwb_src_t write_src,
  output dsmd_pkg::dsmd_half_t write_half,
  output logic [2:0] output_shift
);
  initial begin
    {data_read_bus, mult_a, mult_b} = 48'h0;
    {input_shift, mult_go, mult_signed, alu_go, write_go, output_shift} = 12'h0;
    product_shift = dsmd_pkg::PSH_NONE;
    alu_op = dsmd_pkg::ALU_LOAD;
    alu_src = dsmd_pkg::SRC_INPUT_SCALER;
    write_src = dsmd_pkg::DWB_OUTPUT_SCALER;
    write_half = dsmd_pkg::HALF_LOW;
  end
  // Data operands mult_a, mult_b and data_read_bus are inverted once a request is taken, so stale values are never reused
  task automatic mul(input logic [15:0] a, b, input logic s, input dsmd_pkg::dsmd_psh_t ps);
    @(negedge sys_clk);
    {mult_a, mult_b, mult_signed, mult_go} = {a, b, s, 1'b1};
    product_shift = ps;
    @(negedge sys_clk);
    {mult_a, mult_b, mult_go} = {~a, ~b, 1'b0};
  endtask
  task automatic alu(input dsmd_pkg::dsmd_alu_op_t o, input dsmd_pkg::dsmd_src_t s,
      input logic [15:0] d, input logic [4:0] sh);
    @(negedge sys_clk);
    alu_op = o;
    alu_src = s;
    {data_read_bus, input_shift, alu_go} = {d, sh, 1'b1};
    @(negedge sys_clk);
    {data_read_bus, alu_go} = {~d, 1'b0};
  endtask
  task automatic wr(input dsmd_pkg::dsmd_dwb_src_t s, input dsmd_pkg::dsmd_half_t h,
      input logic [2:0] sh);
    @(negedge sys_clk);
    write_src = s;
    write_half = h;
    {output_shift, write_go} = {sh, 1'b1};
    @(negedge sys_clk);
    write_go = 1'b0;
  endtask
endmodule // dsmd_ctrl_model

/* verif/dsmd_datapath_bench.sv */
// Self-checking bench for the scaling and multiply datapath
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module dsmd_datapath_bench;
  // Each row: a multiply, then one arithmetic step; e is {carry, accumulator}
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic s;
    dsmd_pkg::dsmd_psh_t p;
    logic [31:0] ep;
    dsmd_pkg::dsmd_alu_op_t o;
    dsmd_pkg::dsmd_src_t src;
    logic [15:0] d;
    logic [4:0] sh;
    logic [32:0] e;
  } dsmd_row_t;
  dsmd_row_t rows [14] = '{
    '{16'hFFFF, 16'h0002, 1'b1, dsmd_pkg::PSH_NONE, 32'hFFFF_FFFE, dsmd_pkg::ALU_LOAD,
      dsmd_pkg::SRC_PRODUCT_SHIFTER, 16'h0000, 5'h00, 33'h0_FFFF_FFFE},
    '{16'hFFFF, 16'h0002, 1'b0, dsmd_pkg::PSH_LEFT1, 32'h0001_FFFE, dsmd_pkg::ALU_LOAD,
      dsmd_pkg::SRC_PRODUCT_SHIFTER, 16'h0000, 5'h00, 33'h0_0003_FFFC},
    '{16'h8000, 16'h0001, 1'b1, dsmd_pkg::PSH_RIGHT6, 32'hFFFF_8000, dsmd_pkg::ALU_LOAD,
      dsmd_pkg::SRC_PRODUCT_SHIFTER, 16'h0000, 5'h00, 33'h0_FFFF_FE00},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_LOAD,
      dsmd_pkg::SRC_PRODUCT_SHIFTER, 16'h0000, 5'h00, 33'h0_0012_3400},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_LOAD,
      dsmd_pkg::SRC_INPUT_SCALER, 16'h8001, 5'h10, 33'h0_8001_0000},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_LOAD,
      dsmd_pkg::SRC_INPUT_SCALER, 16'h8001, 5'h14, 33'h0_8001_0000},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_LOAD,
      dsmd_pkg::SRC_INPUT_SCALER, 16'hFFFF, 5'h00, 33'h0_0000_FFFF},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_ADD,
      dsmd_pkg::SRC_INPUT_SCALER, 16'hFFFF, 5'h10, 33'h0_FFFF_FFFF},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_ADD,
      dsmd_pkg::SRC_INPUT_SCALER, 16'h0001, 5'h00, 33'h1_0000_0000},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_SUB,
      dsmd_pkg::SRC_INPUT_SCALER, 16'h0001, 5'h00, 33'h0_FFFF_FFFF},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_AND,
      dsmd_pkg::SRC_INPUT_SCALER, 16'h0F0F, 5'h04, 33'h0_0000_F0F0},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_OR,
      dsmd_pkg::SRC_INPUT_SCALER, 16'h00FF, 5'h10, 33'h0_00FF_F0F0},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_XOR,
      dsmd_pkg::SRC_INPUT_SCALER, 16'hFFFF, 5'h00, 33'h0_00FF_0F0F},
    '{16'h1234, 16'h0010, 1'b0, dsmd_pkg::PSH_LEFT4, 32'h0001_2340, dsmd_pkg::ALU_SUB,
      dsmd_pkg::SRC_INPUT_SCALER, 16'h0F0F, 5'h00, 33'h1_00FF_0000}};
  logic sys_clk = 1'b0, reset_n = 1'b0, mult_go, mult_signed, alu_go, write_go;
  logic alu_carry, data_write_valid;
  logic [15:0] data_read_bus, mult_a, mult_b, data_write_bus;
  logic [31:0] accumulator_reg, product_holding_reg;
  logic [4:0] input_shift;
  logic [2:0] output_shift;
  dsmd_pkg::dsmd_psh_t product_shift;
  dsmd_pkg::dsmd_alu_op_t alu_op;
  dsmd_pkg::dsmd_src_t alu_src;
  dsmd_pkg::dsmd_dwb_src_t write_src;
  dsmd_pkg::dsmd_half_t write_half;
  int fails = 0, total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  dsmd_datapath uut (.*);
  dsmd_ctrl_model ctl (.*);
  task automatic wrap_up;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rst_chk(input int n);
    reset_n = 1'b0;
    repeat (n) @(negedge sys_clk);
    reset_n = 1'b1;
    `CHK({accumulator_reg, p_chk(), data_write_bus, data_write_valid}, 82'h0)
    $display("reset test done");
  endtask
  function automatic logic [32:0] p_chk();
    return {product_holding_reg, alu_carry};
  endfunction
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    rst_chk(5);
    foreach (rows[i]) begin
      ctl.mul(rows[i].a, rows[i].b, rows[i].s, rows[i].p);
      `CHK(product_holding_reg, rows[i].ep)
      ctl.alu(rows[i].o, rows[i].src, rows[i].d, rows[i].sh);
      `CHK({alu_carry, accumulator_reg}, rows[i].e)
      `CHK(product_holding_reg, rows[i].ep)
      $display("row %0d done", i);
    end
    ctl.wr(dsmd_pkg::DWB_PRODUCT_SHIFTER, dsmd_pkg::HALF_HIGH, 3'h0);
    `CHK({data_write_valid, data_write_bus}, 17'h1_0012)
    ctl.alu(dsmd_pkg::ALU_LOAD, dsmd_pkg::SRC_INPUT_SCALER, 16'h00F1, 5'h04);
    ctl.wr(dsmd_pkg::DWB_OUTPUT_SCALER, dsmd_pkg::HALF_HIGH, 3'h7);
    `CHK(data_write_bus, 16'h0007)
    ctl.wr(dsmd_pkg::DWB_OUTPUT_SCALER, dsmd_pkg::HALF_LOW, 3'h7);
    @(negedge sys_clk);
    `CHK({data_write_valid, data_write_bus}, 17'h0_8800)
    $display("output scaler test done");
    rst_chk(1);
    ctl.mul(16'h0003, 16'h0005, 1'b0, dsmd_pkg::PSH_NONE);
    `CHK(product_holding_reg, 32'h0000_000F)
    $display("restart test done");
    wrap_up();
  end
endmodule // dsmd_datapath_bench
bind dsmd_datapath dsmd_datapath_sva chk (.*);
